// ### rtl/mac_rx_defines.svh
`ifndef MAC_RX_DEFINES_SVH
`define MAC_RX_DEFINES_SVH
// Register byte offsets.
`define OFF_RX_CTRL     8'h00
`define OFF_TX_CTRL     8'h04
`define OFF_RX_STAT     8'h08
`define OFF_TX_STAT     8'h0c
`define OFF_DMA_RX_STAT 8'h10
`define OFF_CTX_STAT    8'h14
`define OFF_MISSED      8'h18
`define OFF_PAUSE_CNT   8'h1c
`define OFF_MGMT        8'h20
// Field positions.
`define BIT_RX_EN       0
`define BIT_PASS        1
`define BIT_SEND_PAUSE  0
`define BIT_OVERRUN     0
`define BIT_MGMT_RD     26
`define BIT_MGMT_BUSY   31
// Frame constants.
`define CTRL_TYPE       16'h8808
`define PAUSE_OPCODE    16'h0001
`define MIN_FRAME       16'h0040
`define CRC_RESIDUE     32'hdebb20e3
`define CRC_POLY        32'hedb88320
`define NIB_PRE         4'h5
`define NIB_SFD         4'hd
// Management frame layout.
`define MG_PRE          32'hffffffff
`define MG_SOF          2'b01
`define MG_OP_WR        2'b01
`define MG_OP_RD        2'b10
`define MG_TA_WR        2'b10
`define MG_RELEASE      7'd46
`define MG_DATA_SAMPLE  7'd49
`define MG_BITS         7'd64
// Pause quantum of 512 bit times is 128 nibble clocks.
`define QUANTUM_NIBS    7'd127
// Reset values and response codes.
`define RST_RX_CTRL     2'h0
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// ### rtl/mac_rx_pkg.sv
package mac_rx_pkg;
  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] d;
  } mii_rx_s;
  typedef struct packed {
    logic       toss;
    logic       last;
    logic [7:0] data;
  } rx_entry_s;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_PRE  = 3'b010,
    RX_DATA = 3'b100
  } rx_state_e;
endpackage

// ### rtl/mac_rx_fifo_mgmt_pause.sv
// Notes on behaviour
// - FIFO written and read on system clock; line clock is sampled.
// - FIFO empty after reset; receive waits for enable.
// - Undrained FIFO may overflow; bytes dropped.
// - Write frame: preamble, 01, 01, addresses, 10, data.
// - Read frame: opcode 10, release, PHY drives data.
// - Five-bit PHY and register address fields.
// - Management clock times every management bit.
// - Pause needs type 8808, 64 bytes, CRC, opcode.
// - Other types are ordinary data frames.
// - Pass-through forwards control frames to software.
// - Pause loads count, signals transmitter and DMA.
// - Counter reaches zero before transmit resumes.
// - New pause reloads counter; zero ends early.
// - Send-pause request honoured even while paused.
// - Control frame transmit result stored in register.
// - Transmit, receive status and missed frame counter.
// - Status values offered to DMA for copying.
// - FIFO overflow sets DMA receive overrun flag.
`include "mac_rx_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module mac_rx_fifo_mgmt_pause import mac_rx_pkg::*; #(
  parameter int AW       = 6,
  parameter int MDC_HALF = 10
) (
  // System clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite register slave.
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // MII receive pins.
  input  wire logic        rx_clk,
  input  wire mii_rx_s     mii_rx,
  // Receive FIFO drain side.
  output logic             rd_valid,
  input  wire logic        rd_ready,
  output rx_entry_s        rd_entry,
  // Management pins.
  output logic             mdc,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe,
  // Transmitter and DMA side.
  output logic             tx_pause,
  output logic             dma_pause,
  output logic             send_pause_req,
  input  wire logic        tx_ctrl_done,
  input  wire logic [15:0] tx_ctrl_result,
  input  wire logic        tx_done,
  input  wire logic [15:0] tx_result,
  output logic [31:0]      dma_rx_status,
  output logic [31:0]      dma_tx_status
);
  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  logic [1:0]  rx_ctrl_r;
  logic        send_r;
  logic        overrun_r, frame_ovr_r, crc_err_r, ctrl_seen_r, hold_v_r, half_r;
  logic [15:0] missed_r, pause_cnt_r, tx_stat_r, ctx_stat_r, cnt_r, type_r, opc_r, opnd_r;
  logic [15:0] rd_data_r;
  logic [31:0] crc_r;
  logic [7:0]  hold_r;
  logic [3:0]  lo_r;
  logic [6:0]  q_cnt_r, bit_r;
  logic [AW:0] wr_ptr_r, rd_ptr_r, wr_gray, rd_gray;
  logic [AW-1:0] rd_next;
  rx_entry_s   mem [2**AW];
  rx_entry_s   wr_data;
  rx_state_e   st_r;
  mii_rx_s     pin_s1, pin_s2;
  logic        clk_s1, clk_s2, clk_s3, mdi_s1, mdi_s2, nib_edge;
  logic        byte_stb, frame_end, wr_req, wr_en, full, empty, pause_hit, is_ctrl;
  logic        aw_h_r, w_h_r, busy_r, mg_rd_r, mdc_r;
  logic [7:0]  aw_r;
  logic [31:0] wd_r;
  logic [63:0] sh_r;
  logic [7:0]  div_r;
  logic        do_wr, div_wrap;

  // Every off-domain pin passes two flops before any logic reads it.
  always_ff @(posedge aclk) begin
    {clk_s1, pin_s1, mdi_s1} <= {rx_clk, mii_rx, mdio_i};
    {clk_s2, pin_s2, mdi_s2} <= {clk_s1, pin_s1, mdi_s1};
    clk_s3 <= clk_s2;
  end
  assign nib_edge = clk_s2 & ~clk_s3;

  // Receive framing: preamble hunt, SFD, then nibble pairing LSB first.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= RX_IDLE;
      half_r <= 1'b0;
      lo_r <= 4'h0;
    end else if (nib_edge) begin
      case (st_r)
        RX_IDLE: if (pin_s2.dv && pin_s2.d == `NIB_PRE && rx_ctrl_r[`BIT_RX_EN]) st_r <= RX_PRE;
        RX_PRE: begin
          if (!pin_s2.dv) st_r <= RX_IDLE;
          else if (pin_s2.d == `NIB_SFD) st_r <= RX_DATA;
          half_r <= 1'b0;
        end
        RX_DATA: begin
          if (!pin_s2.dv) st_r <= RX_IDLE;
          else begin
            half_r <= ~half_r;
            lo_r <= pin_s2.d;
          end
        end
        default: st_r <= RX_IDLE;
      endcase
    end
  end
  assign byte_stb  = nib_edge && st_r == RX_DATA && pin_s2.dv && half_r;
  assign frame_end = nib_edge && st_r == RX_DATA && !pin_s2.dv;

  // Per-frame byte count, CRC and control field capture.
  always_ff @(posedge aclk) begin
    if (!aresetn || (nib_edge && st_r == RX_PRE)) begin
      cnt_r <= 16'h0;
      crc_r <= 32'hffffffff;
      {type_r, opc_r, opnd_r} <= '0;
      crc_err_r <= 1'b0;
    end else begin
      if (nib_edge && st_r == RX_DATA && pin_s2.dv && pin_s2.er) crc_err_r <= 1'b1;
      if (byte_stb) begin
        cnt_r <= (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h1;
        crc_r <= crc_byte(crc_r, {pin_s2.d, lo_r});
        case (cnt_r)
          16'd12: type_r[15:8] <= {pin_s2.d, lo_r};
          16'd13: type_r[7:0]  <= {pin_s2.d, lo_r};
          16'd14: opc_r[15:8]  <= {pin_s2.d, lo_r};
          16'd15: opc_r[7:0]   <= {pin_s2.d, lo_r};
          16'd16: opnd_r[15:8] <= {pin_s2.d, lo_r};
          16'd17: opnd_r[7:0]  <= {pin_s2.d, lo_r};
          default: ;
        endcase
      end
    end
  end
  assign is_ctrl   = type_r == `CTRL_TYPE;
  assign pause_hit = frame_end && is_ctrl && cnt_r >= `MIN_FRAME && crc_r == `CRC_RESIDUE
                     && !crc_err_r && opc_r == `PAUSE_OPCODE;

  // One byte is held back so the frame's final entry can carry its marks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_v_r <= 1'b0;
      hold_r <= 8'h00;
    end else if (byte_stb) begin
      hold_v_r <= 1'b1;
      hold_r <= {pin_s2.d, lo_r};
    end else if (frame_end || (nib_edge && st_r == RX_PRE)) begin
      hold_v_r <= 1'b0;
    end
  end
  assign wr_req = hold_v_r && (byte_stb || frame_end);
  assign wr_data = '{toss: frame_end && is_ctrl && !rx_ctrl_r[`BIT_PASS],
                     last: frame_end, data: hold_r};

  // Gray pointers guard the full and empty compares.
  assign wr_gray  = bin2gray(wr_ptr_r);
  assign rd_gray  = bin2gray(rd_ptr_r);
  assign empty    = wr_gray == rd_gray;
  assign full     = wr_gray == {~rd_gray[AW:AW-1], rd_gray[AW-2:0]};
  assign wr_en    = wr_req && !full;
  assign rd_valid = !empty;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (wr_en) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (rd_valid && rd_ready) rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
  // The head register always holds the slot that the read pointer names, so rd_entry
  // is valid in the same cycle as rd_valid; a write into that slot is forwarded.
  assign rd_next = rd_ptr_r[AW-1:0] + AW'(rd_valid && rd_ready);
  always_ff @(posedge aclk) begin
    if (wr_en) mem[wr_ptr_r[AW-1:0]] <= wr_data;
    rd_entry <= (wr_en && wr_ptr_r[AW-1:0] == rd_next) ? wr_data : mem[rd_next];
  end

  // Overrun is sticky; a new overrun wins over a software clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overrun_r <= 1'b0;
      frame_ovr_r <= 1'b0;
      missed_r <= 16'h0;
      ctrl_seen_r <= 1'b0;
    end else begin
      if (wr_req && full) overrun_r <= 1'b1;
      else if (do_wr && aw_r == `OFF_DMA_RX_STAT && wd_r[`BIT_OVERRUN]) overrun_r <= 1'b0;
      if (wr_req && full) frame_ovr_r <= 1'b1;
      else if (frame_end) frame_ovr_r <= 1'b0;
      if (frame_end && (frame_ovr_r || (wr_req && full))) missed_r <= missed_r + 16'h1;
      if (frame_end) ctrl_seen_r <= is_ctrl;
    end
  end

  // Pause counter in quanta of 512 bit times, timed by the line clock.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pause_cnt_r <= 16'h0;
      q_cnt_r <= 7'h0;
    end else if (pause_hit) begin
      pause_cnt_r <= opnd_r;
      q_cnt_r <= 7'h0;
    end else if (nib_edge && pause_cnt_r != 16'h0) begin
      q_cnt_r <= q_cnt_r + 7'h1;
      if (q_cnt_r == `QUANTUM_NIBS) pause_cnt_r <= pause_cnt_r - 16'h1;
    end
  end
  // Consumers finish any frame in progress before honouring the level.
  assign tx_pause  = pause_cnt_r != 16'h0;
  assign dma_pause = tx_pause;

  // Transmit and control-frame status capture.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_stat_r <= 16'h0;
      ctx_stat_r <= 16'h0;
      send_r <= 1'b0;
    end else begin
      if (tx_done) tx_stat_r <= tx_result;
      if (tx_ctrl_done) ctx_stat_r <= tx_ctrl_result;
      if (do_wr && aw_r == `OFF_TX_CTRL && wd_r[`BIT_SEND_PAUSE]) send_r <= 1'b1;
      else if (tx_ctrl_done) send_r <= 1'b0;
    end
  end
  assign send_pause_req = send_r;
  assign dma_rx_status  = {14'h0, crc_err_r, overrun_r, missed_r};
  assign dma_tx_status  = {ctx_stat_r, tx_stat_r};

  // Management frame engine: drive on falling MDC, sample on rising.
  // Read data passes the two-flop synchroniser, so MDC_HALF must be 3 or more.
  assign div_wrap = div_r == 8'(MDC_HALF - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      mg_rd_r <= 1'b0;
      mdc_r <= 1'b0;
      div_r <= 8'h0;
      bit_r <= 7'h0;
      sh_r <= 64'h0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
      rd_data_r <= 16'h0;
    end else if (!busy_r) begin
      if (do_wr && aw_r == `OFF_MGMT) begin
        busy_r <= 1'b1;
        mg_rd_r <= wd_r[`BIT_MGMT_RD];
        div_r <= 8'h0;
        bit_r <= 7'h0;
        sh_r <= {`MG_PRE, `MG_SOF, wd_r[`BIT_MGMT_RD] ? `MG_OP_RD : `MG_OP_WR,
                 wd_r[25:21], wd_r[20:16],
                 wd_r[`BIT_MGMT_RD] ? 2'b00 : `MG_TA_WR, wd_r[15:0]};
      end
    end else begin
      div_r <= div_wrap ? 8'h0 : div_r + 8'h1;
      if (div_wrap && !mdc_r) begin
        mdc_r <= 1'b1;
        if (mg_rd_r && bit_r >= `MG_DATA_SAMPLE) rd_data_r <= {rd_data_r[14:0], mdi_s2};
      end else if (div_wrap) begin
        mdc_r <= 1'b0;
        if (bit_r == `MG_BITS) begin
          busy_r <= 1'b0;
          mdio_oe <= 1'b0;
        end else begin
          mdio_o <= sh_r[63];
          mdio_oe <= !(mg_rd_r && bit_r >= `MG_RELEASE);
          sh_r <= {sh_r[62:0], 1'b0};
          bit_r <= bit_r + 7'h1;
        end
      end
    end
  end
  assign mdc = mdc_r;

  // AXI4-Lite: address and data taken in either order, then one response.
  assign awready = !aw_h_r && !bvalid;
  assign wready  = !w_h_r && !bvalid;
  assign do_wr   = aw_h_r && w_h_r && !bvalid;
  assign arready = !rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_h_r, w_h_r, bvalid} <= 3'b000;
      aw_r <= 8'h00;
      wd_r <= 32'h0;
      bresp <= `RESP_OKAY;
      rx_ctrl_r <= `RST_RX_CTRL;
    end else begin
      if (awvalid && awready) {aw_h_r, aw_r} <= {1'b1, awaddr};
      if (wvalid && wready) {w_h_r, wd_r} <= {1'b1, wdata & {{8{wstrb[3]}}, {8{wstrb[2]}},
                                                      {8{wstrb[1]}}, {8{wstrb[0]}}}};
      if (do_wr) begin
        {aw_h_r, w_h_r, bvalid} <= 3'b001;
        bresp <= (aw_r > `OFF_MGMT || aw_r[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
        if (aw_r == `OFF_RX_CTRL) rx_ctrl_r <= wd_r[1:0];
      end else if (bvalid && bready) bvalid <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      case (araddr)
        `OFF_RX_CTRL:     rdata <= {30'h0, rx_ctrl_r};
        `OFF_TX_CTRL:     rdata <= {31'h0, send_r};
        `OFF_RX_STAT:     rdata <= {28'h0, tx_pause, ctrl_seen_r, crc_err_r, overrun_r};
        `OFF_TX_STAT:     rdata <= {16'h0, tx_stat_r};
        `OFF_DMA_RX_STAT: rdata <= {31'h0, overrun_r};
        `OFF_CTX_STAT:    rdata <= {16'h0, ctx_stat_r};
        `OFF_MISSED:      rdata <= {16'h0, missed_r};
        `OFF_PAUSE_CNT:   rdata <= {16'h0, pause_cnt_r};
        `OFF_MGMT:        rdata <= {busy_r, 15'h0, rd_data_r};
        default: begin
          rdata <= 32'h0;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rready) rvalid <= 1'b0;
  end

  // Checks.
  property p_empty_rst; @(posedge aclk) $rose(aresetn) |-> !rd_valid; endproperty
  a_empty_rst: assert property (p_empty_rst) else $error("fifo not empty after reset");
  property p_no_drop_full; @(posedge aclk) disable iff (!aresetn)
    (wr_req && full) |=> overrun_r && $stable(wr_ptr_r); endproperty
  a_no_drop_full: assert property (p_no_drop_full) else $error("overrun not flagged");
  property p_gray; @(posedge aclk) disable iff (!aresetn) $countones(wr_gray ^ $past(wr_gray)) <= 1;
  endproperty
  a_gray: assert property (p_gray) else $error("gray pointer jumped");
  property p_mdio_edge; @(posedge aclk) disable iff (!aresetn) $changed(mdio_o) |-> !mdc;
  endproperty
  a_mdio_edge: assert property (p_mdio_edge) else $error("mdio moved with mdc high");
  property p_release; @(posedge aclk) disable iff (!aresetn)
    (busy_r && mg_rd_r && bit_r > `MG_RELEASE) |-> !mdio_oe; endproperty
  a_release: assert property (p_release) else $error("read frame not released");
  property p_preamble; @(posedge aclk) disable iff (!aresetn)
    (mdio_oe && bit_r <= 7'd32) |-> mdio_o; endproperty
  a_preamble: assert property (p_preamble) else $error("preamble bit not one");
  property p_load; @(posedge aclk) disable iff (!aresetn) pause_hit |=> pause_cnt_r == $past(opnd_r);
  endproperty
  a_load: assert property (p_load) else $error("pause count not loaded");
  property p_dec; @(posedge aclk) disable iff (!aresetn)
    (!pause_hit && nib_edge && tx_pause && q_cnt_r == `QUANTUM_NIBS)
    |=> pause_cnt_r == $past(pause_cnt_r) - 16'h1; endproperty
  a_dec: assert property (p_dec) else $error("pause count not decremented");
  property p_send; @(posedge aclk) disable iff (!aresetn)
    (do_wr && aw_r == `OFF_TX_CTRL && wd_r[0]) |=> send_pause_req; endproperty
  a_send: assert property (p_send) else $error("send pause ignored");
  property p_ctx; @(posedge aclk) disable iff (!aresetn)
    tx_ctrl_done |=> ctx_stat_r == $past(tx_ctrl_result); endproperty
  a_ctx: assert property (p_ctx) else $error("control tx status lost");
  c_pause: cover property (@(posedge aclk) pause_hit);
  c_overflow: cover property (@(posedge aclk) wr_req && full);
  c_mgmt_rd: cover property (@(posedge aclk) busy_r && mg_rd_r ##1 !busy_r);
  c_toss: cover property (@(posedge aclk) wr_en && wr_data.toss);
endmodule
`default_nettype wire

// ### tb/mii_phy_model.sv
`timescale 1ns/1ns
`default_nettype none
module mii_phy_model import mac_rx_pkg::*; (
  // Receive pins toward the MAC.
  output logic      rx_clk,
  output mii_rx_s   mii_rx,
  // Management pins.
  input  wire logic mdc,
  input  wire logic mdio_o,
  input  wire logic mdio_oe,
  output logic      mdio_i
);
  logic [63:0] seen;
  logic [15:0] reg_val = 16'h0;
  logic [5:0]  cnt = 6'h0;
  logic        rd = 1'b0;
  logic        phy_oe = 1'b0;
  logic        phy_o = 1'b0;
  logic        oe_q = 1'b0;

  // The line has a pull-up, so a released line reads high.
  assign mdio_i = mdio_oe ? mdio_o : (phy_oe ? phy_o : 1'b1);

  // Receive pins start quiet.
  initial begin
    rx_clk = 1'b0;
    mii_rx = '0;
  end

  // The clock only runs within frames, plus a short tail so dv low is seen.
  task automatic tick();
    #160 rx_clk = 1'b1;
    #160 rx_clk = 1'b0;
  endtask

  // Nibbles change after the clock falls, low nibble of each byte first.
  task automatic send(input logic [7:0] q[$]);
    // Keep every pin change away from the system clock's edges.
    #10;
    mii_rx.dv = 1'b1;
    repeat (5) begin
      mii_rx.d = 4'h5;
      tick();
    end
    mii_rx.d = 4'hd;
    tick();
    foreach (q[i]) begin
      mii_rx.d = q[i][3:0];
      tick();
      mii_rx.d = q[i][7:4];
      tick();
    end
    mii_rx.dv = 1'b0;
    repeat (2) begin
      mii_rx.d = ~mii_rx.d;
      tick();
    end
  endtask

  // Every bit is taken at the rise of the station's clock; the count restarts when the
  // station first drives, so it names the frame bit that each rise takes.
  always @(posedge mdc) begin
    seen <= {seen[62:0], mdio_i};
    oe_q <= mdio_oe;
    cnt <= (mdio_oe && !oe_q) ? 6'd1 : cnt + 6'd1;
    if (cnt == 6'd35) rd <= {seen[0], mdio_i} == 2'b10;
  end

  // On a read the PHY drives the zero of the turnaround, then data MSB first.
  always @(negedge mdc) begin
    phy_oe <= rd && cnt >= 6'd47;
    phy_o <= (cnt == 6'd47) ? 1'b0 : reg_val[4'(6'd63 - cnt)];
  end
endmodule
`default_nettype wire

// ### tb/tb.sv
`include "mac_rx_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module tb import mac_rx_pkg::*; ;
  logic        aclk, awready, wready, bvalid, arready, rvalid, rx_clk, rd_valid, mdc;
  logic        mdio_i, mdio_o, mdio_oe, tx_pause, dma_pause, send_pause_req;
  logic        aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        rd_ready = 0, hold = 0, ovf = 0, rx_en = 0, tx_ctrl_done = 0, tx_done = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, dma_rx_status, dma_tx_status, v, m;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] tx_ctrl_result = 0, tx_result = 0, o;
  mii_rx_s     mii_rx;
  rx_entry_s   rd_entry;
  int          mismatches = 0, tests_run = 0, e, n;
  int          exp_q[$];

  // The MDC half period leaves room for the read-data synchroniser.
  mac_rx_fifo_mgmt_pause #(.AW(3), .MDC_HALF(4)) mac_rx_fifo_mgmt_pause_inst (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .rx_clk, .mii_rx, .rd_valid, .rd_ready, .rd_entry,
    .mdc, .mdio_i, .mdio_o, .mdio_oe, .tx_pause, .dma_pause, .send_pause_req,
    .tx_ctrl_done, .tx_ctrl_result, .tx_done, .tx_result, .dma_rx_status, .dma_tx_status);
  mii_phy_model mii_phy_model_inst (.rx_clk, .mii_rx, .mdc, .mdio_o, .mdio_oe, .mdio_i);

  // System clock, 40 ns.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    tests_run++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw = 0;
    bit w = 0;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'b111;
    awaddr <= a;
    wdata <= d;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) awvalid <= 1'b0;
      if (!w && wready) wvalid <= 1'b0;
      aw = aw || awready;
      w = w || wready;
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    {arvalid, rready} <= 2'b11;
    araddr <= a;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Reference frame check sequence, reflected form.
  function automatic logic [31:0] crc(input logic [7:0] q[$]);
    logic [31:0] c = 32'hffffffff;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    return ~c;
  endfunction

  // Builds a frame, queues the bytes the FIFO must show, and sends it.
  task automatic frame(input logic [15:0] t, input logic [15:0] op, input logic [15:0] p,
                       input int len, input bit bad, input logic [1:0] tc);
    logic [7:0]  q[$];
    logic [31:0] c;
    q = {8'h01, 8'h80, 8'hc2, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
         8'h05, t[15:8], t[7:0], op[15:8], op[7:0], p[15:8], p[7:0]};
    while (q.size() < len - 4) q.push_back(8'($urandom));
    c = crc(q) ^ {31'h0, bad};
    for (int i = 0; i < 32; i += 8) q.push_back(c[i +: 8]);
    if (rx_en && !ovf) foreach (q[i]) exp_q.push_back({tc, i == q.size() - 1, q[i]});
    mii_phy_model_inst.send(q);
    repeat (20) @(posedge aclk);
  endtask

  // The load lands on the first tail clock, so no quantum has passed yet.
  task automatic pchk(input logic [15:0] x);
    axi_rd(`OFF_PAUSE_CNT, v);
    chk(v, x);
    chk(tx_pause, x != 0);
    chk(dma_pause, x != 0);
  endtask

  // Drain side: every entry outside the overflow test is compared with the reference queue.
  always @(posedge aclk) begin
    rd_ready <= !hold;
    if (rd_valid === 1'b1 && rd_ready === 1'b1 && !ovf) begin
      chk(exp_q.size() != 0, 1);
      e = exp_q.pop_front();
      chk(rd_entry.data, e[7:0]);
      chk(rd_entry.last, e[8]);
      if (e[8] && e[10:9] != 0) chk(rd_entry.toss, e[10:9] == 2);
    end
  end

  // The run needs about 16500 cycles.
  initial begin
    repeat (80000) @(posedge aclk);
    mismatches++;
    summarize();
  end

  initial begin
    v = $urandom(32'he90c06ab);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`OFF_RX_CTRL, v);
    chk(v, 0);
    axi_rd(8'h40, v);
    chk({v, r}, {32'h0, `RESP_SLVERR});
    axi_wr(8'h40, 32'h0);
    chk(r, `RESP_SLVERR);
    frame(`CTRL_TYPE, `PAUSE_OPCODE, 16'h0007, 64, 0, 0);
    chk(rd_valid, 0);
    axi_wr(`OFF_RX_CTRL, 32'h1);
    chk(r, `RESP_OKAY);
    rx_en = 1;
    // Near misses must not pause; none of these four frames qualifies.
    frame(16'h0800, `PAUSE_OPCODE, 16'h0003, 64, 0, 1);
    frame(`CTRL_TYPE, `PAUSE_OPCODE, 16'h0003, 64, 1, 0);
    frame(`CTRL_TYPE, `PAUSE_OPCODE, 16'h0003, 63, 0, 0);
    frame(`CTRL_TYPE, 16'h0002, 16'h0003, 64, 0, 0);
    pchk(0);
    o = 16'($urandom_range(16'hffff, 16'h0100));
    frame(`CTRL_TYPE, `PAUSE_OPCODE, o, 64, 0, 2);
    pchk(o);
    axi_rd(`OFF_RX_STAT, v);
    chk(v[3:2], 2'b11);
    axi_wr(`OFF_RX_CTRL, 32'h3);
    o = 16'($urandom_range(16'hffff, 16'h0100));
    frame(`CTRL_TYPE, `PAUSE_OPCODE, o, 64, 0, 1);
    pchk(o);
    // Send-pause request while the transmitter is paused.
    axi_wr(`OFF_TX_CTRL, 32'h1);
    chk(send_pause_req, 1);
    @(posedge aclk);
    {tx_ctrl_done, tx_done} <= 2'b11;
    tx_ctrl_result <= 16'($urandom);
    tx_result <= 16'($urandom);
    @(posedge aclk);
    {tx_ctrl_done, tx_done} <= 2'b00;
    @(posedge aclk);
    chk(send_pause_req, 0);
    axi_rd(`OFF_CTX_STAT, v);
    chk(v[15:0], tx_ctrl_result);
    axi_rd(`OFF_TX_STAT, v);
    chk(v[15:0], tx_result);
    chk(dma_tx_status, {tx_ctrl_result, tx_result});
    frame(`CTRL_TYPE, `PAUSE_OPCODE, 16'h0000, 64, 0, 1);
    pchk(0);
    frame(`CTRL_TYPE, `PAUSE_OPCODE, 16'h0002, 64, 0, 1);
    pchk(2);
    frame(16'h0800, `PAUSE_OPCODE, 16'h0000, 200, 0, 1);
    pchk(0);
    // One management write, then one read.
    for (int i = 0; i < 2; i++) begin
      o = 16'($urandom);
      v = $urandom;
      mii_phy_model_inst.reg_val = 16'($urandom);
      axi_wr(`OFF_MGMT, {5'h0, i[0], v[9:0], o});
      repeat (4) @(posedge aclk);
      n = 0;
      do axi_rd(`OFF_MGMT, m); while (m[31] && n++ < 200);
      chk(n < 200, 1);
      if (i == 0) chk(mii_phy_model_inst.seen, {32'hffffffff, 4'b0101, v[9:0], 2'b10, o});
      else chk(mii_phy_model_inst.seen[63:16], {32'hffffffff, 4'b0110, v[9:0], 2'b10});
      if (i == 1) chk(m[15:0], mii_phy_model_inst.reg_val);
    end
    // A stalled drain lets the FIFO overflow.
    hold <= 1'b1;
    ovf = 1;
    frame(16'h0800, `PAUSE_OPCODE, 16'h0000, 40, 0, 0);
    axi_rd(`OFF_DMA_RX_STAT, v);
    chk(v[0], 1);
    chk(dma_rx_status[16:0], 17'h10001);
    axi_rd(`OFF_MISSED, v);
    chk(v, 1);
    hold <= 1'b0;
    n = 0;
    while (rd_valid === 1'b1 && n++ < 100) @(posedge aclk);
    @(posedge aclk);
    ovf = 0;
    chk(rd_valid, 0);
    axi_wr(`OFF_DMA_RX_STAT, 32'h1);
    axi_rd(`OFF_DMA_RX_STAT, v);
    chk(v[0], 0);
    frame(16'h0800, `PAUSE_OPCODE, 16'h0000, 64, 0, 1);
    repeat (50) @(posedge aclk);
    chk(exp_q.size(), 0);
    summarize();
  end
endmodule
`default_nettype wire
